// *** rsa_rail_strobe_assignment.sv ***
/*
  Rail strobe assignment: three password-protected registers and a small
  up/down strobe sequencer driving six rail enables.
  Assumes an internal register port on the system clock, an unlock level
  from the password logic, and a seal flag and start pulses from the same
  clock domain.
*/
`timescale 1ns/1ps
module rsa_rail_strobe_assignment #(
  parameter int DLY_SHORT = rsa_pkg::DLY_SHORT_CYC,
  parameter int DLY_LONG  = rsa_pkg::DLY_LONG_CYC
) (
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  // Register port
  input  wire logic       i_reg_wr,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  // Control
  input  wire logic       i_unlocked,
  input  wire logic       i_freshness_seal_flag,
  input  wire logic [9:1] i_step_delay_select,
  input  wire logic       i_powerdown_delay_factor,
  input  wire logic       i_power_up,
  input  wire logic       i_power_down,
  // Rail enables: buck_boost, buck_three, backup_1v8, backup_1v0, switch, ldo
  output logic      [5:0] o_rail_en,
  output logic            o_seq_busy
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_STROBE = 3'b010,
    ST_WAIT  = 3'b100
  } rsa_state_t;

  typedef struct packed {
    rsa_state_t           st;
    logic                 down;
    logic [3:0]           strobe;
    logic [rsa_pkg::CNT_W-1:0] cnt;
    logic [7:0]           buck;
    logic [7:0]           backup;
    logic [7:0]           swldo;
    logic [7:0]           rdata;
    logic [5:0]           en;
    logic                 busy;
  } rsa_regs_t;

  rsa_regs_t  s_r;
  rsa_regs_t  s_nxt;
  logic [5:0] hit;
  logic [2:0] sel;

  rsa_strobe_decode u_dec (
    .i_buck   (s_r.buck),
    .i_backup (s_r.backup),
    .i_swldo  (s_r.swldo),
    .i_strobe (s_r.strobe),
    .o_hit    (hit)
  );

  // One-hot register select: bit 0 buck pair, bit 1 backup pair, bit 2 switch and regulator.
  // Shared by the write path and the read path so both always see the same map.
  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    if (a == rsa_pkg::OFS_BUCK) begin
      reg_sel = 3'h1;
    end else if (a == rsa_pkg::OFS_BACKUP) begin
      reg_sel = 3'h2;
    end else if (a == rsa_pkg::OFS_SWLDO) begin
      reg_sel = 3'h4;
    end else begin
      reg_sel = 3'h0;
    end
  endfunction

  // True on the strobe that closes a pass: the last one going up, strobe 1 going down
  function automatic logic last_strobe(input logic [3:0] s, input logic dn);
    if (dn) begin
      last_strobe = (s == 4'h1);
    end else begin
      last_strobe = (s == rsa_pkg::STROBE_LAST);
    end
  endfunction

  // Strobe that follows s in the current direction
  function automatic logic [3:0] next_strobe(input logic [3:0] s, input logic dn);
    if (dn) begin
      next_strobe = s - 4'h1;
    end else begin
      next_strobe = s + 4'h1;
    end
  endfunction

  // Rail enables after strobe s has been issued
  function automatic logic [5:0] apply_strobe(input logic [5:0] cur, input logic [5:0] h,
                                              input logic [3:0] s, input logic dn,
                                              input logic seal);
    logic [5:0] keep;
    // Backup rails sit at bits 2 and 3; with the seal broken they neither go up nor down
    keep = seal ? 6'h33 : 6'h3F;
    if (s <= 4'h2 && seal) begin
      apply_strobe = cur;
    end else if (!dn) begin
      apply_strobe = cur | h;
    end else begin
      apply_strobe = cur & ~(h & keep);
    end
  endfunction

  function automatic logic [rsa_pkg::CNT_W-1:0] step_delay(input logic [3:0] s, input logic dn,
                                                           input logic [9:1] sel, input logic fct);
    logic [rsa_pkg::CNT_W-1:0] base;
    base = (s >= 4'h1 && s <= 4'h9 && sel[s]) ? rsa_pkg::CNT_W'(DLY_LONG)
                                              : rsa_pkg::CNT_W'(DLY_SHORT);
    // Factor applies on the way down only; power-up timing is untouched
    step_delay = (dn && fct) ? rsa_pkg::CNT_W'(base * rsa_pkg::PD_FACTOR) : base;
  endfunction

  always_comb begin
    s_nxt = s_r;
    sel   = reg_sel(i_reg_addr);
    // Writes ignored while locked; the password logic owns the unlock level
    if (i_reg_wr && i_unlocked) begin
      if (sel[0]) begin
        s_nxt.buck[rsa_pkg::HI_LSB +: 4] = i_reg_wdata[rsa_pkg::HI_LSB +: 4];
        s_nxt.buck[rsa_pkg::LO_LSB +: 4] = i_reg_wdata[rsa_pkg::LO_LSB +: 4];
      end
      if (sel[1]) begin
        // Reserved bits are never stored, so they always read back as zero
        s_nxt.backup = i_reg_wdata & rsa_pkg::BACKUP_MASK;
      end
      if (sel[2]) begin
        s_nxt.swldo[rsa_pkg::HI_LSB +: 4] = i_reg_wdata[rsa_pkg::HI_LSB +: 4];
        s_nxt.swldo[rsa_pkg::LO_LSB +: 4] = i_reg_wdata[rsa_pkg::LO_LSB +: 4];
      end
    end
    // Read data trails the address by one edge and shows the value before a same-cycle write
    if (sel[0]) begin
      s_nxt.rdata = s_r.buck;
    end else if (sel[1]) begin
      s_nxt.rdata = s_r.backup;
    end else if (sel[2]) begin
      s_nxt.rdata = s_r.swldo;
    end else begin
      s_nxt.rdata = 8'h00;
    end

    // Busy is kept in its own flop so the output needs no decode after the state register

    case (s_r.st)
      ST_IDLE: begin
        // Power-up wins when both pulses arrive together
        if (i_power_up) begin
          s_nxt.down   = 1'b0;
          s_nxt.strobe = 4'h1;
          s_nxt.st     = ST_STROBE;
          s_nxt.busy   = 1'b1;
        end else if (i_power_down) begin
          s_nxt.down   = 1'b1;
          s_nxt.strobe = rsa_pkg::STROBE_LAST;
          s_nxt.st     = ST_STROBE;
          s_nxt.busy   = 1'b1;
        end
      end
      ST_STROBE: begin
        // Seal is read live at every strobe, so breaking it mid-pass takes effect at once
        s_nxt.en  = apply_strobe(s_r.en, hit, s_r.strobe, s_r.down, i_freshness_seal_flag);
        s_nxt.cnt = step_delay(s_r.down ? s_r.strobe - 4'h1 : s_r.strobe, s_r.down,
                               i_step_delay_select, i_powerdown_delay_factor);
        if (last_strobe(s_r.strobe, s_r.down)) begin
          s_nxt.st   = ST_IDLE;
          s_nxt.busy = 1'b0;
        end else begin
          s_nxt.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Each step lasts the loaded count plus the strobe cycle itself
        if (s_r.cnt <= rsa_pkg::CNT_W'(1)) begin
          s_nxt.strobe = next_strobe(s_r.strobe, s_r.down);
          s_nxt.st     = ST_STROBE;
        end else begin
          s_nxt.cnt = s_r.cnt - rsa_pkg::CNT_W'(1);
        end
      end
      default: begin
        s_nxt.st   = ST_IDLE;
        s_nxt.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_r        <= '0;
      s_r.st     <= ST_IDLE;
      s_r.buck   <= rsa_pkg::RST_BUCK;
      s_r.backup <= rsa_pkg::RST_BACKUP;
      s_r.swldo  <= rsa_pkg::RST_SWLDO;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_reg_rdata = s_r.rdata;
  assign o_rail_en   = s_r.en;
  assign o_seq_busy  = s_r.busy;
endmodule // rsa_rail_strobe_assignment

// *** rsa_pkg.sv ***
/*
  Package for the rail strobe assignment block: register offsets, field
  positions, reset values, code ranges and timing counts.
  Assumes a 20 MHz system clock and a simple internal register port.
*/
// Function
// - A four-bit field holding 3h to Ah enables its rail at that strobe.
// - Four-bit codes 0h-2h and Bh-Fh leave the rail outside sequencer control.
// - Backup fields: 1h strobe 1, 2h strobe 2, 0h and 3h uncontrolled.
// - Strobes 1 and 2 run only while the freshness seal flag is 0.
// - Once the seal is broken, backup rails are never disabled by the sequencer.
// - Offset 0x23: buck-boost in bits 7-4, buck three in 3-0, reset 0x8A.
// - Offset 0x24: 1.8 V backup bits 5-4, 1 V bits 1-0, reset 0x12.
// - Offset 0x25: switch bits 7-4, linear regulator bits 3-0, reset 0xA7.
// - Inter-strobe delay is 2 ms with select bit clear, 5 ms when set.
// - Delay factor bit multiplies delays by ten during power-down only.
package rsa_pkg;
  localparam logic [7:0] OFS_BUCK    = 8'h23;
  localparam logic [7:0] OFS_BACKUP  = 8'h24;
  localparam logic [7:0] OFS_SWLDO   = 8'h25;
  localparam logic [7:0] RST_BUCK    = 8'h8A;
  localparam logic [7:0] RST_BACKUP  = 8'h12;
  localparam logic [7:0] RST_SWLDO   = 8'hA7;
  localparam logic [7:0] BACKUP_MASK = 8'h33;
  localparam int HI_LSB = 4;
  localparam int LO_LSB = 0;
  localparam int B18_LSB = 4;
  localparam int B10_LSB = 0;
  localparam logic [3:0] STROBE_MIN_WIDE = 4'h3;
  localparam logic [3:0] STROBE_MAX_WIDE = 4'hA;
  localparam logic [3:0] STROBE_LAST     = 4'hA;
  localparam int NUM_RAILS = 6;
  localparam int CLK_HZ = 20000000;
  localparam int DLY_SHORT_MS = 2;
  localparam int DLY_LONG_MS  = 5;
  localparam int PD_FACTOR    = 10;
  localparam int DLY_SHORT_CYC = CLK_HZ / 1000 * DLY_SHORT_MS;
  localparam int DLY_LONG_CYC  = CLK_HZ / 1000 * DLY_LONG_MS;
  localparam int CNT_W = 24;
endpackage

// *** rsa_strobe_decode.sv ***
/*
  Rail strobe decoder: turns the stored fields into one enable mask for
  the strobe now being issued. Purely combinational; same clock as caller.
*/
`timescale 1ns/1ps
module rsa_strobe_decode (
  // Fields
  input  wire logic [7:0] i_buck,
  input  wire logic [7:0] i_backup,
  input  wire logic [7:0] i_swldo,
  // Strobe
  input  wire logic [3:0] i_strobe,
  output logic      [5:0] o_hit
);
  function automatic logic wide_hit(input logic [3:0] f, input logic [3:0] s);
    // Codes outside 3h..Ah never match any strobe
    wide_hit = (f >= rsa_pkg::STROBE_MIN_WIDE) && (f <= rsa_pkg::STROBE_MAX_WIDE) && (f == s);
  endfunction

  function automatic logic narrow_hit(input logic [1:0] f, input logic [3:0] s);
    narrow_hit = ((f == 2'h1) && (s == 4'h1)) || ((f == 2'h2) && (s == 4'h2));
  endfunction

  always_comb begin
    o_hit[0] = wide_hit(i_buck[rsa_pkg::HI_LSB +: 4], i_strobe);
    o_hit[1] = wide_hit(i_buck[rsa_pkg::LO_LSB +: 4], i_strobe);
    o_hit[2] = narrow_hit(i_backup[rsa_pkg::B18_LSB +: 2], i_strobe);
    o_hit[3] = narrow_hit(i_backup[rsa_pkg::B10_LSB +: 2], i_strobe);
    o_hit[4] = wide_hit(i_swldo[rsa_pkg::HI_LSB +: 4], i_strobe);
    o_hit[5] = wide_hit(i_swldo[rsa_pkg::LO_LSB +: 4], i_strobe);
  end
endmodule // rsa_strobe_decode

// *** rsa_chk.sv ***
/* Checker for the rail strobe assignment block.
   Bound onto the top module; sees its ports only. */
`timescale 1ns/1ps
module rsa_chk (
  // Watched inputs
  input wire logic       i_sys_clk,
  input wire logic       i_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic       i_unlocked,
  input wire logic       i_freshness_seal_flag,
  input wire logic       i_power_up,
  input wire logic       i_power_down,
  // Watched outputs
  input wire logic [7:0] o_reg_rdata,
  input wire logic [5:0] o_rail_en,
  input wire logic       o_seq_busy
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  reset_clear_a: assert property ($fell(i_rst) |-> o_rail_en == 6'h00 && !o_seq_busy)
    else $error("outputs not cleared");
  locked_hold_a: assert property ((!i_unlocked && $stable(i_reg_addr)) [*3] |-> $stable(o_reg_rdata))
    else $error("locked write landed");
  backup_resv_a: assert property ($past(i_reg_addr) == 8'h24 |-> (o_reg_rdata & 8'hCC) == 8'h00)
    else $error("reserved bits set");
  unmapped_zero_a: assert property ($past(i_reg_addr) > 8'h25 |-> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  seq_start_a: assert property ((i_power_up || i_power_down) && !o_seq_busy |=> o_seq_busy)
    else $error("sequence did not start");
  idle_steady_a: assert property (!o_seq_busy ##1 !o_seq_busy |-> $stable(o_rail_en))
    else $error("rails moved while idle");
  seal_keep_a: assert property (i_freshness_seal_flag |=> !$fell(o_rail_en[2]) && !$fell(o_rail_en[3]))
    else $error("backup rail dropped");
  seal_skip_a: assert property (i_freshness_seal_flag |=> !$rose(o_rail_en[2]) && !$rose(o_rail_en[3]))
    else $error("early strobe ran");
endmodule // rsa_chk

// *** rsa_rail_strobe_assignment_test.sv ***
/* Bench for the rail strobe assignment block: registers, then up/down runs.
   Drives every input itself; short delay parameters stand in for 2/5 ms. */
`timescale 1ns/1ps
module rsa_rail_strobe_assignment_test;
  logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, unl = 1'b0, busy;
  logic       seal = 1'b0, fct = 1'b0, pu = 1'b0, pd = 1'b0;
  logic [7:0] addr = 8'h00, wd = 8'h00, rd;
  logic [9:1] dsel = 9'h000;
  logic [5:0] en, m = 6'h00;
  logic [7:0] v [3];
  logic [7:0] cn [3] = '{8'hA3, 8'h21, 8'h2B};
  int         seed = 71, mismatches = 0, n_tests = 0, cyc = 0, n_run = 0;

  rsa_rail_strobe_assignment #(.DLY_SHORT(4), .DLY_LONG(10)) u_dut (.i_sys_clk(clk), .i_rst(rst),
    .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rd), .i_unlocked(unl),
    .i_freshness_seal_flag(seal), .i_step_delay_select(dsel), .i_powerdown_delay_factor(fct),
    .i_power_up(pu), .i_power_down(pd), .o_rail_en(en), .o_seq_busy(busy));

  initial forever #25 clk = ~clk;
  // Slow power-down passes dominate; the full run stays under 5000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    if (mismatches == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] g, e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wreg(input logic [7:0] a, d);
    @(negedge clk);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, e);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    cmp({8'h00, rd}, {8'h00, e});
  endtask
  // Counts the busy cycles of one pass
  task automatic run(input logic up, output int n);
    @(negedge clk);
    pu = up;
    pd = !up;
    @(negedge clk);
    pu = 1'b0;
    pd = 1'b0;
    n = 0;
    while (n < 3000 && busy === 1'b1) begin
      @(negedge clk);
      n++;
    end
  endtask
  // Ten strobe cycles plus nine delays of 4 or 10 cycles, ten times longer going down with the factor
  function automatic int dur(input logic dn);
    int t;
    t = 10;
    for (int k = 1; k <= 9; k++) t += (dsel[k] ? 10 : 4) * ((dn && fct) ? 10 : 1);
    return t;
  endfunction
  function automatic logic w(input logic [3:0] x);
    return x >= 4'h3 && x <= 4'hA;
  endfunction
  // Rails the sequencer owns; backup rails drop out once the seal is set
  function automatic logic [5:0] ctl(input logic s);
    return {w(v[2][3:0]), w(v[2][7:4]), !s && (v[1][1:0] inside {2'h1, 2'h2}),
            !s && (v[1][5:4] inside {2'h1, 2'h2}), w(v[0][3:0]), w(v[0][7:4])};
  endfunction

  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    rreg(8'h23, 8'h8A);
    rreg(8'h24, 8'h12);
    rreg(8'h25, 8'hA7);
    rreg(8'h40, 8'h00);
    wreg(8'h25, 8'h00);
    rreg(8'h25, 8'hA7);
    unl = 1'b1;
    for (int i = 0; i < 8; i++) begin
      for (int j = 0; j < 3; j++) begin
        v[j] = i == 0 ? cn[j] : 8'($random(seed));
        wreg(8'(8'h23 + j), v[j]);
      end
      for (int j = 0; j < 3; j++) rreg(8'(8'h23 + j), j == 1 ? v[j] & rsa_pkg::BACKUP_MASK : v[j]);
      dsel = 9'($random(seed));
      fct = i[1];
      seal = i[0];
      m = m | ctl(seal);
      run(1'b1, n_run);
      cmp(16'(n_run), 16'(dur(1'b0)));
      cmp({10'h000, en}, {10'h000, m});
      seal = i[2];
      m = m & ~ctl(seal);
      run(1'b0, n_run);
      cmp(16'(n_run), 16'(dur(1'b1)));
      cmp({10'h000, en}, {10'h000, m});
    end
    wrap_up();
  end
endmodule // rsa_rail_strobe_assignment_test

bind rsa_rail_strobe_assignment rsa_chk u_chk (.i_sys_clk, .i_rst, .i_reg_addr, .i_unlocked,
  .i_freshness_seal_flag, .i_power_up, .i_power_down, .o_reg_rdata, .o_rail_en, .o_seq_busy);
